// ==== src/etc_top.sv ====
// apb register front end for the error tally control block
// assumes fault pulses arrive from detectors clocked by pclk
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps

module etc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_frame_crc_fault,
   input wire logic stream_parity_fault,
   input wire logic frame_crc_fault,
   input wire logic decode_fault,
   input wire logic header_mismatch_fault,
   output logic irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] ctl_reg; // error_count_control
   logic [7:0] ctl_next;
   logic [7:0] mask_reg; // interrupt mask 0
   logic [7:0] mask_next;
   logic flag_reg; // error_tally_overflow_flag
   logic flag_next;
   logic [31:0] rdata_reg; // read data captured in setup
   logic [31:0] rdata_next;
   logic setup; // apb setup phase
   logic access; // apb access phase
   logic hit; // address is mapped
   logic wr; // write takes effect

   etc_tally_if tif ();

   etc_tally u_tally (
      .pclk(pclk),
      .presetn(presetn),
      .tif(tif)
   );

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign hit = (paddr == etc_pkg::ADDR_CTL) || (paddr == etc_pkg::ADDR_TALLY) ||
                (paddr == etc_pkg::ADDR_MASK0) || (paddr == etc_pkg::ADDR_PEND0);
   assign wr = access & pwrite & hit;
   assign pready = 1'b1; // zero wait states
   assign pslverr = access & ~hit; // unmapped address

   // feed the counter
   assign tif.fault_hits = {irq_frame_crc_fault, stream_parity_fault, frame_crc_fault,
                            decode_fault, header_mismatch_fault};
   assign tif.class_en = ctl_reg[etc_pkg::CLASS_MSB:0];
   assign tif.level = ctl_reg[etc_pkg::LEVEL_MSB:etc_pkg::LEVEL_LSB];
   assign tif.clear = wr && (paddr == etc_pkg::ADDR_TALLY);

   // next register values
   always_comb begin
      ctl_next = ctl_reg;
      mask_next = mask_reg;
      flag_next = flag_reg;
      rdata_next = rdata_reg;
      // software writes
      if (wr && paddr == etc_pkg::ADDR_CTL) begin
         ctl_next = pwdata[7:0];
      end
      if (wr && paddr == etc_pkg::ADDR_MASK0) begin
         mask_next = pwdata[7:0];
      end
      // write one to clear the flag, a new crossing wins
      if (wr && paddr == etc_pkg::ADDR_PEND0 && pwdata[etc_pkg::FLAG_BIT]) begin
         flag_next = 1'b0;
      end
      if (tif.over) begin
         flag_next = 1'b1;
      end
      // read data captured in setup, shown in access
      if (setup) begin
         case (paddr)
            etc_pkg::ADDR_CTL: begin
               rdata_next = {24'h000000, ctl_reg};
            end
            etc_pkg::ADDR_TALLY: begin
               rdata_next = {24'h000000, tif.count};
            end
            etc_pkg::ADDR_MASK0: begin
               rdata_next = {24'h000000, mask_reg};
            end
            etc_pkg::ADDR_PEND0: begin
               rdata_next = 32'h00000000;
               rdata_next[etc_pkg::FLAG_BIT] = flag_reg;
            end
            default: begin
               rdata_next = 32'h00000000;
            end
         endcase
      end
   end

   // register stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= etc_pkg::CTL_RESET;
         mask_reg <= etc_pkg::MASK_RESET;
         flag_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ctl_reg <= ctl_next;
         mask_reg <= mask_next;
         flag_reg <= flag_next;
         rdata_reg <= rdata_next;
      end
   end

   assign prdata = rdata_reg;
   assign irq = flag_reg & mask_reg[etc_pkg::FLAG_BIT];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // a crossing pulse always lands in the flag
   property p_flag_set;
      @(posedge pclk) disable iff (!presetn)
         tif.over |=> flag_reg;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("overflow flag not raised");

   // a crossing with the mask bit set reaches the pin one edge later
   property p_irq_gate;
      @(posedge pclk) disable iff (!presetn)
         (tif.over && mask_reg[etc_pkg::FLAG_BIT] && !(wr && paddr == etc_pkg::ADDR_MASK0))
         |=> irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not raised with mask set");

   // with the mask bit clear the pin stays low whatever the flag does
   property p_irq_masked;
      @(posedge pclk) disable iff (!presetn)
         !mask_reg[etc_pkg::FLAG_BIT] |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq raised while masked");

   // the flag stays up until software writes one to it
   property p_flag_hold;
      @(posedge pclk) disable iff (!presetn)
         (flag_reg && !(wr && paddr == etc_pkg::ADDR_PEND0 && pwdata[etc_pkg::FLAG_BIT]))
         |=> flag_reg;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("overflow flag dropped by itself");

   // write one to clear takes the flag down when no crossing competes
   property p_flag_clear;
      @(posedge pclk) disable iff (!presetn)
         (wr && paddr == etc_pkg::ADDR_PEND0 && pwdata[etc_pkg::FLAG_BIT] && !tif.over)
         |=> !flag_reg;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("overflow flag not cleared");

   // only a crossing pulse may raise the flag
   property p_flag_quiet;
      @(posedge pclk) disable iff (!presetn)
         (!flag_reg && !tif.over) |=> !flag_reg;
   endproperty
   a_flag_quiet: assert property (p_flag_quiet) else $error("overflow flag raised early");

   // a control write reaches the level code and the class enables
   property p_ctl_write;
      @(posedge pclk) disable iff (!presetn)
         (wr && paddr == etc_pkg::ADDR_CTL)
         |=> tif.level == $past(pwdata[7:5]) && tif.class_en == $past(pwdata[4:0]);
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("control write not applied");

   // the tally seen at the setup edge is what the access phase shows
   property p_tally_read;
      @(posedge pclk) disable iff (!presetn)
         (setup && paddr == etc_pkg::ADDR_TALLY)
         |=> prdata == {24'h000000, $past(tif.count)};
   endproperty
   a_tally_read: assert property (p_tally_read) else $error("tally read data wrong");

   // the control register reads back as written
   property p_ctl_read;
      @(posedge pclk) disable iff (!presetn)
         (setup && paddr == etc_pkg::ADDR_CTL)
         |=> prdata == {24'h000000, $past(ctl_reg)};
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control read data wrong");

   // with every class disabled and no clear the tally does not move
   property p_disabled_quiet;
      @(posedge pclk) disable iff (!presetn)
         (tif.class_en == 5'h00 && !tif.clear) |=> tif.count == $past(tif.count);
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled class counted");

   // any write to the tally register restarts it from zero
   property p_write_clears;
      @(posedge pclk) disable iff (!presetn)
         (access && pwrite && paddr == etc_pkg::ADDR_TALLY && tif.fault_hits == 5'h00)
         |=> tif.count == 8'h00;
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("tally write did not clear");
endmodule

// ==== src/etc_pkg.sv ====
// constants shared by the error tally control block and its counter
// assumes a 32-bit apb slave with 12-bit byte addresses
package etc_pkg;
   // ----------------------------------------------------------------
   // register indices and byte addresses (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_MASK0 = 10'h01b; // interrupt mask 0
   localparam logic [9:0] IDX_CTL = 10'h01e; // error_count_control
   localparam logic [9:0] IDX_TALLY = 10'h01f; // error tally count
   localparam logic [9:0] IDX_PEND0 = 10'h03f; // pending flags zero
   localparam logic [11:0] ADDR_MASK0 = {IDX_MASK0, 2'h0};
   localparam logic [11:0] ADDR_CTL = {IDX_CTL, 2'h0};
   localparam logic [11:0] ADDR_TALLY = {IDX_TALLY, 2'h0};
   localparam logic [11:0] ADDR_PEND0 = {IDX_PEND0, 2'h0};
   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int NUM_CLASSES = 5; // counted fault classes
   localparam int LEVEL_LSB = 5; // irq_count_level is bits 7:5
   localparam int LEVEL_MSB = 7;
   localparam int CLASS_MSB = 4; // class enables are bits 4:0
   localparam int FLAG_BIT = 5; // overflow flag / irq enable bit
   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] TALLY_MAX = 8'hff; // saturation point
   localparam logic [9:0] LEVEL_BASE = 10'h002; // code 0 means 2 faults
endpackage

// ==== src/etc_tally_if.sv ====
// carrier between the register front end and the tally counter
// assumes both ends run on pclk
`timescale 1ns/100ps
interface etc_tally_if;
   logic [4:0] fault_hits; // one-cycle fault pulses, bit order as control
   logic [4:0] class_en; // per-class count enables
   logic [2:0] level; // irq_count_level code
   logic clear; // software write to the tally
   logic [7:0] count; // current tally
   logic over; // one-cycle pulse when the level is crossed
   modport ctl (output fault_hits, class_en, level, clear, input count, over);
   modport cnt (input fault_hits, class_en, level, clear, output count, over);
endinterface

// ==== src/etc_tally.sv ====
// saturating error tally with threshold crossing detection
// assumes fault pulses and clear are synchronous to pclk
`timescale 1ns/100ps
module etc_tally (
   input wire logic pclk,
   input wire logic presetn,
   etc_tally_if.cnt tif
);
   logic [7:0] count_reg; // tally
   logic [7:0] count_next;
   logic over_reg; // crossing pulse
   logic over_next;
   logic [4:0] gated; // enabled faults this cycle
   logic [2:0] inc; // how many to add
   logic [9:0] base; // start value after optional clear
   logic [9:0] sum; // unsaturated new value
   logic [9:0] level_cnt; // fault count that raises the flag

   // ----------------------------------------------------------------
   // per-class gating
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < etc_pkg::NUM_CLASSES; g = g + 1) begin : g_gate
         assign gated[g] = tif.fault_hits[g] & tif.class_en[g];
      end
   endgenerate

   // next tally: every enabled class with a fault pulse adds one, a clear restarts from zero
   always_comb begin
      inc = 3'h0;
      for (int i = 0; i < etc_pkg::NUM_CLASSES; i++) begin
         inc = inc + {2'h0, gated[i]};
      end
      base = tif.clear ? 10'h000 : {2'h0, count_reg};
      sum = base + {7'h00, inc};
      level_cnt = etc_pkg::LEVEL_BASE << tif.level;
      // saturate instead of wrapping
      if (sum > {2'h0, etc_pkg::TALLY_MAX}) begin
         count_next = etc_pkg::TALLY_MAX;
      end else begin
         count_next = sum[7:0];
      end
      // pulse as the unsaturated sum reaches the selected level; at code 7 each fault at 255 pulses again
      over_next = (base < level_cnt) && (sum >= level_cnt);
   end

   // register the tally
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 8'h00;
         over_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         over_reg <= over_next;
      end
   end

   assign tif.count = count_reg;
   assign tif.over = over_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_level_two;
      @(posedge pclk) disable iff (!presetn)
         (tif.level == 3'h0 && count_reg == 8'h01 && !tif.clear && inc == 3'h1)
         |=> over_reg && count_reg == 8'h02;
   endproperty
   a_level_two: assert property (p_level_two) else $error("level 0 not raised at 2");

   property p_irq_crc;
      @(posedge pclk) disable iff (!presetn)
         (tif.class_en[4] && tif.fault_hits == 5'h10 && !tif.clear && count_reg != 8'hff)
         |=> count_reg == $past(count_reg) + 8'h01;
   endproperty
   a_irq_crc: assert property (p_irq_crc) else $error("irq frame crc fault not counted");

   property p_parity;
      @(posedge pclk) disable iff (!presetn)
         (!tif.class_en[3] && tif.fault_hits == 5'h08 && !tif.clear)
         |=> count_reg == $past(count_reg);
   endproperty
   a_parity: assert property (p_parity) else $error("disabled parity fault counted");

   property p_frame_crc;
      @(posedge pclk) disable iff (!presetn)
         (tif.class_en == 5'h04 && tif.fault_hits == 5'h10 && !tif.clear)
         |=> count_reg == $past(count_reg);
   endproperty
   a_frame_crc: assert property (p_frame_crc) else $error("frame crc enable counted irq crc");

   property p_decode;
      @(posedge pclk) disable iff (!presetn)
         (tif.class_en[1] && tif.fault_hits == 5'h02 && !tif.clear && count_reg != 8'hff)
         |=> count_reg == $past(count_reg) + 8'h01;
   endproperty
   a_decode: assert property (p_decode) else $error("decode fault not counted");

   property p_header;
      @(posedge pclk) disable iff (!presetn)
         (tif.class_en[0] && tif.fault_hits == 5'h01 && !tif.clear && count_reg != 8'hff)
         |=> count_reg == $past(count_reg) + 8'h01;
   endproperty
   a_header: assert property (p_header) else $error("header mismatch not counted");

   property p_clear;
      @(posedge pclk) disable iff (!presetn)
         (tif.clear && gated == 5'h00) |=> count_reg == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("tally not cleared by write");

   property p_saturate;
      @(posedge pclk) disable iff (!presetn)
         (count_reg == 8'hff && !tif.clear) |=> count_reg == 8'hff;
   endproperty
   a_saturate: assert property (p_saturate) else $error("tally wrapped");

   property p_sum_all;
      @(posedge pclk) disable iff (!presetn)
         (tif.class_en == 5'h1f && tif.fault_hits == 5'h1f && !tif.clear && count_reg < 8'h80)
         |=> count_reg == $past(count_reg) + 8'h05;
   endproperty
   a_sum_all: assert property (p_sum_all) else $error("simultaneous faults not all added");
endmodule

// ==== sim/etc_top_tb_top.sv ====
// self-checking bench for the error tally control block
// assumes the apb slave answers with pready and faults are pclk pulses
`timescale 1ns/100ps
module etc_top_tb_top;
   // ----------------------------------------------------------------
   // stimulus rows
   // ----------------------------------------------------------------
   typedef struct {logic [7:0] ctl; logic [4:0] flt; logic [7:0] cnt;} etc_row_t;
   etc_row_t rows[12] = '{'{8'h10, 5'h1f, 8'h01}, '{8'h08, 5'h1f, 8'h01},
      '{8'h04, 5'h1f, 8'h01}, '{8'h02, 5'h1f, 8'h01}, '{8'h01, 5'h1f, 8'h01},
      '{8'h00, 5'h1f, 8'h00}, '{8'h1f, 5'h1f, 8'h05}, '{8'h1a, 5'h0b, 8'h02},
      '{8'h10, 5'h10, 8'h01}, '{8'h04, 5'h10, 8'h00}, '{8'h17, 5'h08, 8'h00},
      '{8'h01, 5'h01, 8'h01}};
   logic pclk = 1'b0; // bus clock
   logic presetn; // async reset, driven low at time zero so its edge is seen
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] flt = 5'h00; // fault pulses, bit order as control
   logic irq;
   logic [31:0] rd; // last read data
   logic er; // last error response
   int err_count = 0;
   int tests_run = 0;
   int thr; // expected fault count to flag
   // ----------------------------------------------------------------
   // design and clock
   // ----------------------------------------------------------------
   etc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_frame_crc_fault(flt[4]), .stream_parity_fault(flt[3]),
      .frame_crc_fault(flt[2]), .decode_fault(flt[1]), .header_mismatch_fault(flt[0]),
      .irq(irq));
   always #50 pclk = ~pclk;
   // ----------------------------------------------------------------
   // helper tasks
   // ----------------------------------------------------------------
   // verdict and end of run
   task automatic finish_test();
      if (err_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // compare seen against expected
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, waiting for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         err_count++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // read a register and compare its word
   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(nm, rd, exp);
   endtask
   // hold the given fault lines high for n cycles
   task automatic burst(input logic [4:0] m, input int n);
      @(posedge pclk);
      flt <= m;
      repeat (n) @(posedge pclk);
      flt <= 5'h00;
      repeat (3) @(posedge pclk);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("ctl reset", etc_pkg::ADDR_CTL, 32'h0);
      check("slverr ok", {31'h0, er}, 32'h0);
      rdchk("mask reset", etc_pkg::ADDR_MASK0, 32'h0);
      rdchk("tally reset", etc_pkg::ADDR_TALLY, 32'h0);
      // each class counted only under its own enable
      foreach (rows[i]) begin
         apb(1'b1, etc_pkg::ADDR_CTL, {24'h0, rows[i].ctl});
         apb(1'b1, etc_pkg::ADDR_TALLY, 32'h0);
         burst(rows[i].flt, 1);
         rdchk("tally", etc_pkg::ADDR_TALLY, {24'h0, rows[i].cnt});
      end
      // every level code, irq masked on even codes
      for (int n = 0; n < 8; n++) begin
         thr = 1 << (n + 1);
         apb(1'b1, etc_pkg::ADDR_CTL, {24'h0, n[2:0], 5'h02});
         apb(1'b1, etc_pkg::ADDR_MASK0, n[0] ? 32'h20 : 32'h0);
         apb(1'b1, etc_pkg::ADDR_TALLY, 32'h0);
         apb(1'b1, etc_pkg::ADDR_PEND0, 32'h20);
         burst(5'h02, thr - 1);
         rdchk("flag early", etc_pkg::ADDR_PEND0, 32'h0);
         check("irq early", {31'h0, irq}, 32'h0);
         rdchk("tally level", etc_pkg::ADDR_TALLY, thr - 1);
         burst(5'h02, 1);
         rdchk("flag", etc_pkg::ADDR_PEND0, 32'h20);
         check("irq", {31'h0, irq}, {31'h0, n[0]});
         rdchk("tally sat", etc_pkg::ADDR_TALLY, (thr > 255) ? 255 : thr);
      end
      // any write clears the tally
      apb(1'b1, etc_pkg::ADDR_TALLY, 32'h5a);
      rdchk("tally clear", etc_pkg::ADDR_TALLY, 32'h0);
      // control is eight bits wide, upper bits read zero
      apb(1'b1, etc_pkg::ADDR_CTL, 32'hffffffff);
      rdchk("ctl wide", etc_pkg::ADDR_CTL, 32'hff);
      // unmapped address is refused
      apb(1'b1, 12'h000, 32'hff);
      check("slverr wr", {31'h0, er}, 32'h1);
      rdchk("unmapped", 12'h000, 32'h0);
      check("slverr rd", {31'h0, er}, 32'h1);
      // flag from the last level still drives the unmasked irq
      check("irq hold", {31'h0, irq}, 32'h1);
      // reset in mid-run restores defaults
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      check("irq rerst", {31'h0, irq}, 32'h0);
      rdchk("ctl rerst", etc_pkg::ADDR_CTL, 32'h0);
      rdchk("mask rerst", etc_pkg::ADDR_MASK0, 32'h0);
      rdchk("flag rerst", etc_pkg::ADDR_PEND0, 32'h0);
      finish_test();
   end
endmodule
